// ---- hdl/adc_ctl_top.sv ----
// Converter control and result registers behind a classic Wishbone slave
//
// How it works
// - Monitor works only while enable bit set
// - Direction bit picks smaller or larger test
// - Select code picks result; 1xxx priority
// - Source bits pick trigger pin or timer
// - Start enables gate each hardware start
// - Pin trigger owned by priority blocks normal
// - Write 10 then 01 resets converter
// - Soft reset clears control bits; reprogram
// - Stored flag sets on store, clears on lower byte read
// - Overrun sets on unread overwrite, clears on lower byte read
`default_nettype none

module adc_ctl_top
  import adc_ctl_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Converter core side
  input  wire logic             result_valid_i,
  input  wire logic [3:0]       result_index_i,
  input  wire logic [RES_W-1:0] result_data_i,
  input  wire logic [RES_W-1:0] compare_value_i,
  // Start sources
  input  wire logic             timer5_compare_match_i,
  input  wire logic             timer6_compare_match_i,
  input  wire logic             external_start_trigger_i,
  // Control outputs
  output logic                  priority_start_o,
  output logic                  normal_start_o,
  output logic                  converter_reset_o,
  output logic                  irq_o
);

  // Bus decode
  logic             req;                            // New access this cycle
  logic             wr_en;                          // Write with low lane
  logic             rd_en;                          // Read access
  logic             wr_mon;                         // Monitor control write
  logic             wr_trig;                        // Trigger control write
  logic             wr_stat;                        // Status clear write
  logic             wr_mask;                        // Mask write
  logic [7:0]       rdata;                          // Selected read byte

  // Control state
  logic [7:0]       mon_ctrl_r;                     // Monitor control
  logic [7:0]       trig_ctrl_r;                    // Trigger control, low bits zero
  logic             srst_armed_r;                   // First reset code seen
  logic             soft_rst;                       // Second code while armed

  // Interrupt state
  logic [IRQ_W-1:0] irq_stat_r;                     // Sticky events
  logic [IRQ_W-1:0] irq_mask_r;                     // Enables
  logic [IRQ_W-1:0] irq_ev;                         // Raw events
  logic [IRQ_W-1:0] irq_clr;                        // Write-one-to-clear bits

  // Pin trigger synchroniser and filter
  logic [2:0]       ext_sync_r;                     // Three stages
  logic             ext_lvl_r;                      // Accepted level
  logic             ext_rise;                       // Accepted rising edge

  // Start decisions
  logic             ext_to_prio;                    // Priority owns the pin
  logic             hp_fire;                        // Priority start now
  logic             nm_fire;                        // Normal start now

  // Result plumbing
  result_evt_s      evt;                            // Store from core
  logic [7:0]       r0_lo;
  logic [7:0]       r0_hi;
  logic [7:0]       r1_lo;
  logic [7:0]       r1_hi;
  logic             ovr0_evt;
  logic             ovr1_evt;
  logic             mon_hit;

  assign evt = '{valid: result_valid_i, idx: result_index_i, data: result_data_i};

  // One access per ack; the ack cycle itself is never a new request
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = req && wb_we_i && wb_sel_i[0];
  assign rd_en   = req && !wb_we_i;
  assign wr_mon  = wr_en && (wb_adr_i == OFS_MON_CTRL);
  assign wr_trig = wr_en && (wb_adr_i == OFS_TRIG_CTRL);
  assign wr_stat = wr_en && (wb_adr_i == OFS_IRQ_STAT);
  assign wr_mask = wr_en && (wb_adr_i == OFS_IRQ_MASK);

  // Second code only counts on the next trigger control write after the first
  assign soft_rst = wr_trig && srst_armed_r && (wb_dat_i[1:0] == SRST_SECOND);

  // Acknowledge every access one cycle after it is taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    unique case (wb_adr_i)
      OFS_MON_CTRL:  rdata = mon_ctrl_r;
      OFS_TRIG_CTRL: rdata = trig_ctrl_r;           // Reset field reads zero
      OFS_RES0_LO:   rdata = r0_lo;
      OFS_RES0_HI:   rdata = r0_hi;
      OFS_RES1_LO:   rdata = r1_lo;
      OFS_RES1_HI:   rdata = r1_hi;
      OFS_IRQ_STAT:  rdata = {5'h00, irq_stat_r};
      OFS_IRQ_MASK:  rdata = {5'h00, irq_mask_r};
      default:       rdata = 8'h00;
    endcase
  end

  // Read data registered with the ack; upper bits always zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (rd_en)
      wb_dat_o <= {24'h00_0000, rdata};
    else
      wb_dat_o <= 32'h0000_0000;
  end

  // Monitor control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst)
      mon_ctrl_r <= MON_CTRL_RST;
    else if (wr_mon)
      mon_ctrl_r <= wb_dat_i[7:0] & MON_RW_MASK;
  end

  // Trigger control; a soft reset beats the bits written with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst)
      trig_ctrl_r <= TRIG_CTRL_RST;
    else if (wr_trig)
      trig_ctrl_r <= wb_dat_i[7:0] & TRIG_RW_MASK;
  end

  // Soft reset sequencer; any other code disarms it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      srst_armed_r <= 1'b0;
    else if (wr_trig)
      srst_armed_r <= (wb_dat_i[1:0] == SRST_FIRST);
  end

  // Reset pulse to the converter core
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      converter_reset_o <= 1'b0;
    else
      converter_reset_o <= soft_rst;
  end

  // Pin trigger: first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ext_sync_r <= 3'h0;
    else
      ext_sync_r <= {ext_sync_r[1:0], external_start_trigger_i};
  end

  // Level accepted only when the last two stages agree, filtering glitches
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ext_lvl_r <= 1'b0;
    else if (ext_sync_r[1] == ext_sync_r[2])
      ext_lvl_r <= ext_sync_r[2];
  end

  assign ext_rise = (ext_sync_r[1] == ext_sync_r[2]) && ext_sync_r[2] && !ext_lvl_r;

  // Start selection; the pin path is kept although software should use timers
  assign ext_to_prio = trig_ctrl_r[HP_EN_BIT] && !trig_ctrl_r[HP_SRC_BIT];
  assign hp_fire = trig_ctrl_r[HP_EN_BIT] &&
                   (trig_ctrl_r[HP_SRC_BIT] ? timer5_compare_match_i : ext_rise);
  assign nm_fire = trig_ctrl_r[NM_EN_BIT] &&
                   (trig_ctrl_r[NM_SRC_BIT] ? timer6_compare_match_i
                                            : (ext_rise && !ext_to_prio));

  // Registered start strobes
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst)
    begin
      priority_start_o <= 1'b0;
      normal_start_o   <= 1'b0;
    end
    else
    begin
      priority_start_o <= hp_fire;
      normal_start_o   <= nm_fire;
    end
  end

  // Result pairs 0 and 1
  result_slot #(.IDX(4'h0)) u_res0 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .clear_i   (soft_rst),
    .evt_i     (evt),
    .rd_lo_i   (rd_en && (wb_adr_i == OFS_RES0_LO)),
    .rd_hi_i   (rd_en && (wb_adr_i == OFS_RES0_HI)),
    .lo_o      (r0_lo),
    .hi_o      (r0_hi),
    .ovr_evt_o (ovr0_evt)
  );

  result_slot #(.IDX(4'h1)) u_res1 (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .clear_i   (soft_rst),
    .evt_i     (evt),
    .rd_lo_i   (rd_en && (wb_adr_i == OFS_RES1_LO)),
    .rd_hi_i   (rd_en && (wb_adr_i == OFS_RES1_HI)),
    .lo_o      (r1_lo),
    .hi_o      (r1_hi),
    .ovr_evt_o (ovr1_evt)
  );

  // Monitor watches every store, not only pairs 0 and 1
  result_monitor u_mon (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .en_i  (mon_ctrl_r[MON_EN_BIT]),
    .dir_i (mon_ctrl_r[MON_DIR_BIT]),
    .sel_i (mon_ctrl_r[MON_SEL_LSB +: 4]),
    .cmp_i (compare_value_i),
    .evt_i (evt),
    .hit_o (mon_hit)
  );

  // Event vector for the status register
  always_comb
  begin
    irq_ev               = '0;
    irq_ev[IRQ_MON_BIT]  = mon_hit;
    irq_ev[IRQ_OVR0_BIT] = ovr0_evt;
    irq_ev[IRQ_OVR1_BIT] = ovr1_evt;
  end

  assign irq_clr = wr_stat ? wb_dat_i[IRQ_W-1:0] : '0;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_r <= IRQ_RST;
    else
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
  end

  // Mask register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask_r <= IRQ_RST;
    else if (wr_mask)
      irq_mask_r <= wb_dat_i[IRQ_W-1:0];
  end

  // Level interrupt, one cycle behind the status register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat_r & irq_mask_r);
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Checker keeps its own note of the last trigger write, apart from the sequencer it watches
  logic             arm_seen_r;                     // Last trigger write carried the arming code
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      arm_seen_r <= 1'b0;
    else if (wr_trig)
      arm_seen_r <= (wb_dat_i[1:0] == SRST_FIRST);
  end
  // Soft reset steps; any other trigger write in between breaks the pair
  sequence srst_arm_s;
    wr_trig && wb_dat_i[1:0] == SRST_FIRST;
  endsequence
  sequence srst_fire_s;
    wr_trig && wb_dat_i[1:0] == SRST_SECOND && arm_seen_r;
  endsequence
  soft_reset_a: assert property (srst_arm_s ##[1:40] srst_fire_s |=>
    converter_reset_o)
    else $error("soft reset sequence ignored");
  reset_clears_a: assert property (soft_rst |=> trig_ctrl_r == TRIG_CTRL_RST &&
    mon_ctrl_r == MON_CTRL_RST && !priority_start_o)
    else $error("soft reset left control bits");
  timer_start_a: assert property (trig_ctrl_r[HP_EN_BIT] && trig_ctrl_r[HP_SRC_BIT] &&
    timer5_compare_match_i && !soft_rst |=> priority_start_o)
    else $error("timer 5 match did not start");
  start_gate_a: assert property (!trig_ctrl_r[NM_EN_BIT] |=> !normal_start_o)
    else $error("normal start while disabled");
  pin_owned_a: assert property (ext_to_prio && !trig_ctrl_r[NM_SRC_BIT] |=> !normal_start_o)
    else $error("pin started normal while owned");
  upper_zero_a: assert property (rd_en && wb_adr_i == OFS_RES0_LO |=>
    wb_ack_o && wb_dat_o[31:8] == 24'h00_0000 && wb_dat_o[5:2] == 4'h0)
    else $error("result low byte unused bits set");
  monitor_irq_a: assert property (mon_hit && irq_mask_r[IRQ_MON_BIT] && !wr_mask |=> ##1 irq_o)
    else $error("monitor event gave no interrupt");

endmodule // adc_ctl_top

`default_nettype wire

// ---- hdl/adc_ctl_pkg.sv ----
// Shared constants, types and helpers for the converter control block
`default_nettype none

package adc_ctl_pkg;

  // Geometry
  localparam int unsigned RES_W   = 10;             // Result width in bits
  localparam int unsigned ADR_W   = 8;              // Byte address bits decoded
  localparam int unsigned IRQ_W   = 3;              // Number of interrupt sources

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFS_MON_CTRL  = 8'h00;     // Monitor control
  localparam logic [7:0] OFS_TRIG_CTRL = 8'h04;     // Hardware start and soft reset
  localparam logic [7:0] OFS_RES0_LO   = 8'h08;     // Result 0 low byte and flags
  localparam logic [7:0] OFS_RES0_HI   = 8'h0c;     // Result 0 upper eight bits
  localparam logic [7:0] OFS_RES1_LO   = 8'h10;     // Result 1 low byte and flags
  localparam logic [7:0] OFS_RES1_HI   = 8'h14;     // Result 1 upper eight bits
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;     // Sticky event bits, write one to clear
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1c;     // Interrupt enables

  // Monitor control fields
  localparam int unsigned MON_EN_BIT  = 0;          // Monitor enable
  localparam int unsigned MON_SEL_LSB = 1;          // Four-bit result select
  localparam int unsigned MON_DIR_BIT = 5;          // 0 smaller, 1 larger
  localparam logic [7:0]  MON_RW_MASK = 8'h3f;      // Bits 7:6 read zero

  // Trigger control fields
  localparam int unsigned HP_SRC_BIT   = 7;         // Priority source, 1 timer 5
  localparam int unsigned HP_EN_BIT    = 6;         // Priority hardware start enable
  localparam int unsigned NM_SRC_BIT   = 5;         // Normal source, 1 timer 6
  localparam int unsigned NM_EN_BIT    = 4;         // Normal hardware start enable
  localparam logic [7:0]  TRIG_RW_MASK = 8'hf0;     // Soft reset field is write-only
  localparam logic [1:0]  SRST_FIRST   = 2'b10;     // Arms the soft reset
  localparam logic [1:0]  SRST_SECOND  = 2'b01;     // Fires it when armed

  // Values after reset
  localparam logic [7:0]       MON_CTRL_RST  = 8'h00;
  localparam logic [7:0]       TRIG_CTRL_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST       = 3'h0;

  // Interrupt status bit positions
  localparam int unsigned IRQ_MON_BIT  = 0;         // Monitor condition met
  localparam int unsigned IRQ_OVR0_BIT = 1;         // Result 0 overrun
  localparam int unsigned IRQ_OVR1_BIT = 2;         // Result 1 overrun

  // Result index of the top-priority result register
  localparam logic [3:0] PRIO_IDX = 4'h8;

  // One stored result from the converter core
  typedef struct packed {
    logic             valid;                        // One-cycle store strobe
    logic [3:0]       idx;                          // 0..7 numbered, 8 priority
    logic [RES_W-1:0] data;                         // Converted value
  } result_evt_s;

  // Select codes 0xxx name a numbered register, 1xxx the priority one
  function automatic logic sel_hits(input logic [3:0] sel, input logic [3:0] idx);
    return sel[3] ? (idx == PRIO_IDX) : (idx == sel);
  endfunction

  // Lower result byte: two low result bits, zeros, overrun, stored
  function automatic logic [7:0] lo_byte(input logic [RES_W-1:0] d, input logic ovr, input logic rf);
    return {d[1:0], 4'h0, ovr, rf};
  endfunction

endpackage : adc_ctl_pkg

`default_nettype wire

// ---- hdl/result_slot.sv ----
// One result register pair with stored and overrun flags
`default_nettype none

module result_slot
  import adc_ctl_pkg::*;
#(
  parameter logic [3:0] IDX = 4'h0                  // Result index served here
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clear_i,                 // Converter soft reset
  input  wire result_evt_s evt_i,                   // Store from converter core
  input  wire logic        rd_lo_i,                 // Lower byte read taken
  input  wire logic        rd_hi_i,                 // Upper byte read taken
  output logic [7:0]       lo_o,                    // Lower byte image
  output logic [7:0]       hi_o,                    // Upper byte image
  output logic             ovr_evt_o                // Overrun happened, pulse
);

  logic [RES_W-1:0] data_r;                         // Held result
  logic             rf_r;                           // Result stored flag
  logic             ovr_r;                          // Overrun flag
  logic             stored_r;                       // Something was ever stored
  logic             hi_rd_r;                        // Upper read since store
  logic             lo_rd_r;                        // Lower read since store
  logic             wr;                             // Store aimed at this slot
  logic             unread;                         // Previous result not fully read

  assign wr     = evt_i.valid && (evt_i.idx == IDX);
  assign unread = stored_r && !(hi_rd_r && lo_rd_r);

  // Result value, split over the two bytes
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      data_r <= '0;
    else if (wr)
      data_r <= evt_i.data;
  end

  // Stored flag: a store in the same cycle as a read wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      rf_r <= 1'b0;
    else if (wr)
      rf_r <= 1'b1;
    else if (rd_lo_i)
      rf_r <= 1'b0;
  end

  // Read tracking; a read racing a store counts for neither the old value nor the new one
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
    begin
      stored_r <= 1'b0;
      hi_rd_r  <= 1'b0;
      lo_rd_r  <= 1'b0;
    end
    else if (wr)
    begin
      stored_r <= 1'b1;
      hi_rd_r  <= 1'b0;
      lo_rd_r  <= 1'b0;
    end
    else
    begin
      hi_rd_r <= hi_rd_r || rd_hi_i;
      lo_rd_r <= lo_rd_r || rd_lo_i;
    end
  end

  // Overrun flag lives in the lower byte, so reading that byte clears it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
    begin
      ovr_r     <= 1'b0;
      ovr_evt_o <= 1'b0;
    end
    else
    begin
      ovr_evt_o <= wr && unread;
      if (wr && unread)
        ovr_r <= 1'b1;
      else if (rd_lo_i)
        ovr_r <= 1'b0;
    end
  end

  assign lo_o = lo_byte(data_r, ovr_r, rf_r);
  assign hi_o = data_r[RES_W-1:2];

  // A store without a soft reset in the same cycle leaves the stored flag up
  stored_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && !clear_i |=> rf_r && data_r == $past(evt_i.data))
    else $error("store did not set flag");

  // Lower read without a store drops both flags
  lo_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_lo_i && !wr |=> !rf_r && !ovr_r)
    else $error("lower read left a flag set");

endmodule // result_slot

`default_nettype wire

// ---- hdl/result_monitor.sv ----
// Compares a selected stored result against the comparison value
`default_nettype none

module result_monitor
  import adc_ctl_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             en_i,               // Monitor enable
  input  wire logic             dir_i,              // 0 smaller, 1 larger
  input  wire logic [3:0]       sel_i,              // Result select code
  input  wire logic [RES_W-1:0] cmp_i,              // Comparison value
  input  wire result_evt_s      evt_i,              // Store from converter core
  output logic                  hit_o               // Condition met, pulse
);

  logic hit_nxt;                                    // Qualifying store this cycle

  // Judge each store as it lands, so each result counts exactly once
  always_comb
  begin
    hit_nxt = 1'b0;
    if (en_i && evt_i.valid && sel_hits(sel_i, evt_i.idx))
      hit_nxt = dir_i ? (evt_i.data > cmp_i) : (evt_i.data < cmp_i);
  end

  // Registered pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hit_o <= 1'b0;
    else
      hit_o <= hit_nxt;
  end

  // Disabled monitor never fires
  mon_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_i |=> !hit_o)
    else $error("monitor fired while disabled");

  // Larger condition fires the next cycle
  mon_larger_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && dir_i && evt_i.valid && sel_hits(sel_i, evt_i.idx) && evt_i.data > cmp_i |=> hit_o)
    else $error("larger result missed");

  // Priority select ignores numbered results
  mon_prio_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_i[3] && evt_i.idx != PRIO_IDX |=> !hit_o)
    else $error("priority select hit numbered result");

endmodule // result_monitor

`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the converter control and result registers
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctl_pkg::*;
  logic             clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i;
  logic [3:0]       wb_sel_i, result_index_i;
  logic [31:0]      wb_dat_i, wb_dat_o;
  logic             result_valid_i, t5, t6, prio_o, norm_o, crst_o, irq_o, rst_seen;
  logic [RES_W-1:0] result_data_i, compare_value_i;
  logic [7:0]       q;
  int               num_errors, num_checks;
  // External pin tied low: software may never select it here
  adc_ctl_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .result_valid_i(result_valid_i), .result_index_i(result_index_i), .result_data_i(result_data_i),
    .compare_value_i(compare_value_i), .timer5_compare_match_i(t5), .timer6_compare_match_i(t6),
    .external_start_trigger_i(1'b0), .priority_start_o(prio_o), .normal_start_o(norm_o),
    .converter_reset_o(crst_o), .irq_o(irq_o));
  // 125 MHz system clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Compare seen against expected
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic Wishbone cycle; answer taken when ack shows
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    // Answer taken at the edge that samples ack high, request released right there
    do
    begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    // A lost ack ends the run as a failure
    if (wb_ack_o !== 1'b1)
    begin
      num_errors++;
      test_done();
    end
    else
    begin
      q = wb_dat_o[7:0];
      rst_seen = crst_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
    end
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(nm, q, exp);
  endtask
  // One stored result from the converter core
  task automatic store(input logic [3:0] idx, input logic [RES_W-1:0] d);
    @(posedge clk_i);
    result_valid_i <= 1'b1;
    result_index_i <= idx;
    result_data_i  <= d;
    @(posedge clk_i);
    result_valid_i <= 1'b0;
  endtask
  // Timer match pulse, start pulses seen the cycle after
  task automatic tmr(input logic a, input logic b, input logic ep, input logic en);
    @(posedge clk_i);
    t5 <= a;
    t6 <= b;
    @(posedge clk_i);
    t5 <= 1'b0;
    t6 <= 1'b0;
    #1;
    check("prio_start", prio_o, ep);
    check("norm_start", norm_o, en);
  endtask
  // Monitor case: program control, store, look at the monitor event bit
  task automatic mon(input logic [7:0] c, input logic [3:0] idx, input logic [RES_W-1:0] d, input logic e);
    bus(1'b1, OFS_MON_CTRL, c);
    store(idx, d);
    bus(1'b0, OFS_IRQ_STAT, 8'h00);
    check("mon_hit", q & 8'h01, {7'h00, e});
    check("mon_irq", irq_o, e);
    bus(1'b1, OFS_IRQ_STAT, 8'h07);
  endtask
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, result_valid_i, t5, t6} = '0;
    {wb_adr_i, wb_dat_i, result_index_i, result_data_i, num_errors, num_checks} = '0;
    wb_sel_i = 4'hf;
    compare_value_i = 10'd100;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, read-only bits, unmapped place
    for (int i = 0; i < 6; i++) rd("reset_val", 8'(i * 4), 8'h00);
    bus(1'b1, OFS_MON_CTRL, 8'hff);
    rd("mon_ctrl", OFS_MON_CTRL, 8'h3f);
    rd("unmapped", 8'h40, 8'h00);
    // Split result, stored flag cleared by lower read
    store(4'h0, 10'h2d5);
    bus(1'b1, OFS_MON_CTRL, 8'h00);
    rd("res0_hi", OFS_RES0_HI, 8'hb5);
    rd("res0_lo", OFS_RES0_LO, 8'h41);
    rd("res0_lo2", OFS_RES0_LO, 8'h40);
    // Unread overwrite gives overrun, status and interrupt
    bus(1'b1, OFS_IRQ_MASK, 8'h04);
    store(4'h1, 10'h001);
    store(4'h1, 10'h3ff);
    repeat (4) @(posedge clk_i);
    #1;
    check("irq_on", irq_o, 1'b1);
    rd("irq_stat", OFS_IRQ_STAT, 8'h04);
    rd("res1_hi", OFS_RES1_HI, 8'hff);
    rd("res1_lo", OFS_RES1_LO, 8'hc3);
    rd("res1_lo2", OFS_RES1_LO, 8'hc0);
    bus(1'b1, OFS_IRQ_STAT, 8'h04);
    repeat (3) @(posedge clk_i);
    #1;
    check("irq_off", irq_o, 1'b0);
    // Only the monitor event unmasked, so its interrupt shows alone
    bus(1'b1, OFS_IRQ_MASK, 8'h01);
    // Monitor table: larger, smaller, priority select, wrong select, disabled
    mon(8'h21, 4'h0, 10'd200, 1'b1);
    mon(8'h01, 4'h0, 10'd200, 1'b0);
    mon(8'h11, 4'h8, 10'd50, 1'b1);
    mon(8'h11, 4'h0, 10'd50, 1'b0);
    mon(8'h30, 4'h8, 10'd900, 1'b0);
    // Hardware starts from timer matches: source before enable, each match alone, then both while disabled
    bus(1'b1, OFS_TRIG_CTRL, 8'h80);
    bus(1'b1, OFS_TRIG_CTRL, 8'hc0);
    bus(1'b1, OFS_TRIG_CTRL, 8'he0);
    bus(1'b1, OFS_TRIG_CTRL, 8'hf0);
    rd("trig_ctrl", OFS_TRIG_CTRL, 8'hf0);
    tmr(1'b1, 1'b0, 1'b1, 1'b0);
    tmr(1'b0, 1'b1, 1'b0, 1'b1);
    bus(1'b1, OFS_TRIG_CTRL, 8'ha0);
    tmr(1'b1, 1'b1, 1'b0, 1'b0);
    // Soft reset: arm, broken sequence, arm, fire
    bus(1'b1, OFS_TRIG_CTRL, 8'hf2);
    bus(1'b1, OFS_TRIG_CTRL, 8'hf0);
    bus(1'b1, OFS_TRIG_CTRL, 8'hf1);
    check("no_reset", rst_seen, 1'b0);
    bus(1'b1, OFS_TRIG_CTRL, 8'hf2);
    bus(1'b1, OFS_TRIG_CTRL, 8'hf1);
    check("conv_reset", rst_seen, 1'b1);
    rd("trig_clr", OFS_TRIG_CTRL, 8'h00);
    rd("mon_clr", OFS_MON_CTRL, 8'h00);
    test_done();
  end
endmodule // tb
`default_nettype wire
